// ---- hdl/rim_pkg.sv ----
// Purpose: Shared constants and carriers for the radio mask and queue port.
// Assumes: One system clock; all strobes are one-cycle pulses.
// Notes:   Offsets are byte addresses in their own register space.
package rim_pkg;
    localparam logic [7:0]  DATA_PORT_ADDR = 8'hD9;
    localparam logic [15:0] EVT_MASK_ADDR  = 16'h61A4;
    localparam logic [15:0] ERR_MASK_ADDR  = 16'h61A5;
    localparam logic [15:0] RX_COUNT_ADDR  = 16'h61A6;
    localparam logic [15:0] TX_COUNT_ADDR  = 16'h61A7;
    localparam int          QUEUE_DEPTH    = 128;
    localparam int          EVT_BITS       = 6;
    localparam int          ERR_BITS       = 7;
    localparam logic [7:0]  DATA_RESET     = 8'h00;
    localparam logic [5:0]  EVT_MASK_RESET = 6'h00;
    localparam logic [6:0]  ERR_MASK_RESET = 7'h00;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    // Event mask bit positions.
    localparam int EVT_ACK_SENT    = 0;
    localparam int EVT_FRAME_SENT  = 1;
    localparam int EVT_RADIO_IDLE  = 2;
    localparam int EVT_SEQ_MANUAL  = 3;
    localparam int EVT_SEQ_HALTED  = 4;
    localparam int EVT_SEQ_RESUMED = 5;
    // Error mask bit positions.
    localparam int ERR_SYNTH_LOCK  = 0;
    localparam int ERR_RX_ABORT    = 1;
    localparam int ERR_RX_OVERFLOW = 2;
    localparam int ERR_RX_UNDER    = 3;
    localparam int ERR_TX_OVERFLOW = 4;
    localparam int ERR_TX_UNDER    = 5;
    localparam int ERR_BAD_STROBE  = 6;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rim_sfr_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } rim_ext_req_t;

    typedef struct packed {
        logic disable_radio;
        logic send_ack;
        logic send_ack_pending;
        logic suppress_ack;
        logic receive_flush;
        logic transmit_flush;
        logic rx_restart;
    } rim_cmd_t;
endpackage

// ---- hdl/rim_skid.sv ----
// Purpose: Two-entry buffer between the transmit queue and the radio.
// Assumes: Output data comes straight from the first entry; valid comes from its own flip-flop.
// Notes:   Flush empties both entries at once.
`timescale 1ns/1ps
`default_nettype none
module rim_skid #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i,
    output logic [1:0]            count_o
);
    typedef struct packed {
        logic [WIDTH-1:0] d0;
        logic [WIDTH-1:0] d1;
        logic [1:0]       cnt;
        logic             vld;
    } skid_state_t;

    skid_state_t s;
    skid_state_t next_s;

    if (WIDTH < 1) begin : g_width_check
        $error("rim_skid: WIDTH must be positive");
    end

    always_comb begin
        next_s = s;
        if (flush_i) begin
            next_s.cnt = 2'd0;
        end else begin
            if (s.cnt != 2'd0 && out_ready_i) begin
                next_s.d0  = s.d1;
                next_s.cnt = 2'(s.cnt - 2'd1);
            end
            if (in_valid_i && s.cnt != 2'd2) begin
                if (next_s.cnt == 2'd0) begin
                    next_s.d0 = in_data_i;
                end else begin
                    next_s.d1 = in_data_i;
                end
                next_s.cnt = 2'(next_s.cnt + 2'd1);
            end
        end
        // Valid has its own flip-flop so the stream output is never a decode of the count.
        next_s.vld = (next_s.cnt != 2'd0);
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_o  = (s.cnt != 2'd2);
    assign out_valid_o = s.vld;
    assign out_data_o  = s.d0;
    assign count_o     = s.cnt;
endmodule
`default_nettype wire

// ---- hdl/rim_top.sv ----
// Purpose: Radio interrupt masks, error event detection and the byte FIFO port.
// Assumes: Pending flag levels come back from the flag registers outside.
// Notes:   Reads answer one cycle after the read strobe.
//
// What this block does
// R1 - Reserved upper bits of both mask registers always read as zero.
// R2 - Event mask bit 5 gates the sequencer resumed-after-wait interrupt.
// R3 - Event mask bit 4 gates the sequencer halted interrupt.
// R4 - Event mask bit 3 gates the sequencer manual interrupt.
// R5 - Event mask bit 2 gates the radio idle entered interrupt.
// R6 - Event mask bit 1 gates the frame sent interrupt.
// R7 - Event mask bit 0 gates the acknowledgement sent interrupt.
// R8 - Disable while disabled, or ack command outside reception, flags strobe error.
// R9 - Error mask bit 6 gates the bad command strobe interrupt.
// R10 - Error mask bit 1 gates the reception aborted interrupt.
// R11 - Error mask bit 0 gates the synthesizer lock failure interrupt.
// R12 - Lock failure stays set until the receiver is restarted.
// R13 - Writing the data port appends the byte to the transmit queue.
// R14 - Reading the data port pops the next byte of the receive queue.
// R15 - Separate receive and transmit fill counts are readable.
// R16 - Flush strobes empty the receive or transmit queue.
// R17 - Each queue holds 128 bytes; receive may hold several frames.
// R18 - Transmit queue holds one frame; software loads the next after sending.
// R19 - Error mask bits 5 to 2 gate tx under, tx over, rx under, rx over.
// R20 - Interrupt only when a pending flag meets a set mask bit; masks reset 0.
`timescale 1ns/1ps
`default_nettype none
module rim_top
    import rim_pkg::*;
#(
    parameter int DEPTH = rim_pkg::QUEUE_DEPTH
) (
    input  wire logic                    clock_i,
    input  wire logic                    rstn_i,
    input  wire rim_pkg::rim_sfr_req_t   sfr_req_i,
    output logic [7:0]                   sfr_rdata_o,
    input  wire rim_pkg::rim_ext_req_t   ext_req_i,
    output logic [7:0]                   ext_rdata_o,
    input  wire rim_pkg::rim_cmd_t       cmd_i,
    input  wire logic                    radio_disabled_i,
    input  wire logic                    rx_active_i,
    input  wire logic                    lock_fail_i,
    input  wire logic                    rx_abort_i,
    input  wire logic [5:0]              evt_pending_i,
    input  wire logic [6:0]              err_pending_i,
    input  wire logic                    rx_valid_i,
    input  wire logic [7:0]              rx_data_i,
    output logic                         tx_valid_o,
    output logic [7:0]                   tx_data_o,
    input  wire logic                    tx_ready_i,
    input  wire logic                    tx_active_i,
    output logic [6:0]                   err_event_o,
    output logic                         lock_error_o,
    output logic                         irq_o
);
    import rim_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    typedef struct packed {
        logic [5:0]    evt_mask;
        logic [6:0]    err_mask;
        logic [PW-1:0] rx_rd;
        logic [PW-1:0] rx_wr;
        logic [CW-1:0] rx_cnt;
        logic [PW-1:0] tx_rd;
        logic [PW-1:0] tx_wr;
        logic [CW-1:0] tx_cnt;
        logic [7:0]    sfr_rdata;
        logic [7:0]    ext_rdata;
        logic [6:0]    err_event;
        logic          lock_error;
        logic          irq;
    } rim_state_t;

    rim_state_t s;
    rim_state_t next_s;

    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];

    logic       port_wr;
    logic       port_rd;
    logic       rx_full;
    logic       tx_full;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic       buf_ready;
    logic [1:0] buf_count;
    logic [7:0] tx_fill;
    logic [7:0] rx_fill;
    logic       bad_strobe;
    logic       tx_under;

    // Fill counts are reported in one byte, so the queue may not grow past 128.
    if (DEPTH < 2 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("rim_top: DEPTH must be a power of two from 2 to 128");
    end

    assign port_wr = sfr_req_i.wr && sfr_req_i.addr == DATA_PORT_ADDR;
    assign port_rd = sfr_req_i.rd && sfr_req_i.addr == DATA_PORT_ADDR;
    assign rx_full = s.rx_cnt == CW'(DEPTH);
    assign tx_full = s.tx_cnt == CW'(DEPTH);

    // A flush drops anything arriving in the same cycle.
    assign rx_push = rx_valid_i && !rx_full && !cmd_i.receive_flush;      // see R17
    assign rx_pop  = port_rd && s.rx_cnt != '0 && !cmd_i.receive_flush;   // see R14
    assign tx_push = port_wr && !tx_full && !cmd_i.transmit_flush;        // see R13
    assign tx_pop  = s.tx_cnt != '0 && buf_ready && !cmd_i.transmit_flush;

    // The radio drains from the buffer; an empty buffer mid-frame is an underflow.
    assign tx_under = tx_active_i && tx_ready_i && !tx_valid_o;

    // Acknowledge commands are only meaningful while actively receiving.
    assign bad_strobe = (cmd_i.disable_radio && radio_disabled_i)
                     || (!rx_active_i && (cmd_i.send_ack || cmd_i.send_ack_pending
                                          || cmd_i.suppress_ack));   // see R8

    // The buffer entries are counted, since those bytes have not been sent yet.
    assign tx_fill = 8'(s.tx_cnt) + 8'(buf_count);   // see R15
    assign rx_fill = 8'(s.rx_cnt);                   // see R15

    rim_skid #(
        .WIDTH (8)
    ) u_skid (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .flush_i     (cmd_i.transmit_flush),
        .in_valid_i  (tx_pop),
        .in_data_i   (tx_mem[s.tx_rd]),
        .in_ready_o  (buf_ready),
        .out_valid_o (tx_valid_o),
        .out_data_o  (tx_data_o),
        .out_ready_i (tx_ready_i),
        .count_o     (buf_count)
    );

    always_comb begin
        next_s = s;

        // Only the low bits are stored, so the reserved bits can never read back.
        if (ext_req_i.wr && ext_req_i.addr == EVT_MASK_ADDR) begin
            next_s.evt_mask = ext_req_i.wdata[EVT_BITS-1:0];   // see R2 R3 R4 R5 R6 R7
        end
        if (ext_req_i.wr && ext_req_i.addr == ERR_MASK_ADDR) begin
            next_s.err_mask = ext_req_i.wdata[ERR_BITS-1:0];   // see R9 R10 R11 R19
        end

        if (ext_req_i.rd) begin
            unique case (ext_req_i.addr)
                EVT_MASK_ADDR: next_s.ext_rdata = {2'b00, s.evt_mask};   // see R1
                ERR_MASK_ADDR: next_s.ext_rdata = {1'b0, s.err_mask};    // see R1
                RX_COUNT_ADDR: next_s.ext_rdata = rx_fill;
                TX_COUNT_ADDR: next_s.ext_rdata = tx_fill;
                default:       next_s.ext_rdata = READ_ZERO;
            endcase
        end

        // An empty receive queue answers zero and reports an underflow.
        if (port_rd) begin
            next_s.sfr_rdata = rx_pop ? rx_mem[s.rx_rd] : READ_ZERO;   // see R14
        end

        // Receive queue pointers and count.
        if (cmd_i.receive_flush) begin
            next_s.rx_rd  = '0;
            next_s.rx_wr  = '0;
            next_s.rx_cnt = '0;   // see R16
        end else begin
            if (rx_push) begin
                next_s.rx_wr = PW'(s.rx_wr + 1'b1);
            end
            if (rx_pop) begin
                next_s.rx_rd = PW'(s.rx_rd + 1'b1);
            end
            next_s.rx_cnt = CW'(s.rx_cnt + CW'(rx_push) - CW'(rx_pop));
        end

        // Transmit queue pointers and count; one frame at a time is assumed.
        if (cmd_i.transmit_flush) begin
            next_s.tx_rd  = '0;
            next_s.tx_wr  = '0;
            next_s.tx_cnt = '0;   // see R16
        end else begin
            if (tx_push) begin
                next_s.tx_wr = PW'(s.tx_wr + 1'b1);   // see R13
            end
            if (tx_pop) begin
                next_s.tx_rd = PW'(s.tx_rd + 1'b1);
            end
            next_s.tx_cnt = CW'(s.tx_cnt + CW'(tx_push) - CW'(tx_pop));   // see R18
        end

        // One-cycle error events towards the flag register.
        next_s.err_event = '0;
        next_s.err_event[ERR_BAD_STROBE]  = bad_strobe;                   // see R8
        next_s.err_event[ERR_TX_UNDER]    = tx_under;                     // see R19
        next_s.err_event[ERR_TX_OVERFLOW] = port_wr && tx_full;           // see R19
        next_s.err_event[ERR_RX_UNDER]    = port_rd && s.rx_cnt == '0;    // see R19
        next_s.err_event[ERR_RX_OVERFLOW] = rx_valid_i && rx_full;        // see R19
        next_s.err_event[ERR_RX_ABORT]    = rx_abort_i;                   // see R10
        next_s.err_event[ERR_SYNTH_LOCK]  = lock_fail_i;                  // see R11

        // A new lock failure in the restart cycle wins, so it is never lost.
        if (lock_fail_i) begin
            next_s.lock_error = 1'b1;   // see R12
        end else if (cmd_i.rx_restart) begin
            next_s.lock_error = 1'b0;   // see R12
        end

        next_s.irq = |(evt_pending_i & s.evt_mask)
                  || |(err_pending_i & s.err_mask);   // see R20
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s          <= '0;
            s.evt_mask <= EVT_MASK_RESET;   // see R20
            s.err_mask <= ERR_MASK_RESET;   // see R20
            s.sfr_rdata <= DATA_RESET;
        end else begin
            s <= next_s;
        end
    end

    // The queues keep their contents over reset; only the pointers are cleared.
    always_ff @(posedge clock_i) begin
        if (rx_push) begin
            rx_mem[s.rx_wr] <= rx_data_i;
        end
        if (tx_push) begin
            tx_mem[s.tx_wr] <= sfr_req_i.wdata;
        end
    end

    assign sfr_rdata_o  = s.sfr_rdata;
    assign ext_rdata_o  = s.ext_rdata;
    assign err_event_o  = s.err_event;
    assign lock_error_o = s.lock_error;
    assign irq_o        = s.irq;
endmodule
`default_nettype wire

// ---- dv/rim_top_sva.sv ----
// Purpose: Port-level timing checks for the radio mask and queue port.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Mask contents are hidden here, so gating is judged in the bench.
`timescale 1ns/1ps
`default_nettype none
module rim_top_sva
    import rim_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              rstn_i,
    input wire rim_pkg::rim_cmd_t cmd_i,
    input wire logic              radio_disabled_i,
    input wire logic              rx_active_i,
    input wire logic              lock_fail_i,
    input wire logic              rx_abort_i,
    input wire logic [5:0]        evt_pending_i,
    input wire logic [6:0]        err_pending_i,
    input wire logic              tx_valid_o,
    input wire logic [7:0]        tx_data_o,
    input wire logic              tx_ready_i,
    input wire logic              tx_active_i,
    input wire logic [6:0]        err_event_o,
    input wire logic              lock_error_o,
    input wire logic              irq_o
);
    import rim_pkg::*;
    logic bad_dis;
    logic bad_ack;
    assign bad_dis = cmd_i.disable_radio && radio_disabled_i;
    assign bad_ack = (cmd_i.send_ack || cmd_i.send_ack_pending || cmd_i.suppress_ack)
                     && !rx_active_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_lock_event: assert property (lock_fail_i |=> err_event_o[0] && lock_error_o)
        else $error("lock failure not reported");
    a_lock_holds: assert property (lock_error_o && !cmd_i.rx_restart |=> lock_error_o)
        else $error("lock error dropped early");
    a_lock_clear: assert property (cmd_i.rx_restart && !lock_fail_i |=> !lock_error_o)
        else $error("lock error not cleared");
    a_abort_event: assert property (rx_abort_i |=> err_event_o[1])
        else $error("abort not reported");
    a_bad_strobe: assert property (bad_dis || bad_ack |=> err_event_o[6])
        else $error("bad strobe not reported");
    a_good_strobe: assert property (!bad_dis && !bad_ack |=> !err_event_o[6])
        else $error("spurious strobe error");
    a_tx_under: assert property (tx_active_i && tx_ready_i && !tx_valid_o |=> err_event_o[5])
        else $error("tx underflow not reported");
    a_irq_quiet: assert property (evt_pending_i == 6'h00 && err_pending_i == 7'h00 |=> !irq_o)
        else $error("irq without pending flag");
    a_tx_stall: assert property (tx_valid_o && !tx_ready_i && !cmd_i.transmit_flush
        |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte lost in stall");
    c_lock: cover property (lock_error_o);
    c_irq: cover property (irq_o);
    c_tx_over: cover property (err_event_o[4]);
endmodule
bind rim_top rim_top_sva u_sva (.*);
`default_nettype wire

// ---- dv/rim_radio_sink.sv ----
// Purpose: Radio transmitter stand-in that drains the transmit stream.
// Assumes: Bench stalls it by stall_i while filling the queue.
// Notes:   Ready is random when not stalled, so the buffer sees stalls too.
`timescale 1ns/1ps
`default_nettype none
module rim_radio_sink (
    input  wire logic clock_i,
    input  wire logic stall_i,
    output logic      tx_ready_o,
    output logic      tx_active_o
);
    initial tx_ready_o = 1'b0;
    initial tx_active_o = 1'b0;
    // The sink takes bytes only while active, and never while stalled.
    always @(negedge clock_i) begin
        tx_ready_o <= !stall_i && ($urandom_range(1) != 0);
        tx_active_o <= !stall_i;
    end
endmodule
`default_nettype wire

// ---- dv/rim_top_tb.sv ----
// Purpose: Self-checking bench for the radio mask and queue port.
// Assumes: DEPTH is cut to 8; the buffer adds two entries to the tx count.
// Notes:   Queues in the bench model both data paths.
`timescale 1ns/1ps
`default_nettype none
module rim_top_tb;
    import rim_pkg::*;
    localparam int D = 8;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    rim_sfr_req_t special_function_register = '0;
    rim_ext_req_t xr = '0;
    rim_cmd_t cmd = '0;
    rim_cmd_t c = '0;
    logic rdis = 1'b0, rxa = 1'b0, lf = 1'b0, ab = 1'b0, rxv = 1'b0, stall = 1'b1;
    logic [5:0] evp = '0;
    logic [6:0] erp = '0;
    logic [7:0] rxd = '0, srd_v, x_v, txd;
    logic txv, txr, txa, le, irq;
    logic [6:0] ev;
    logic [12:0] m;
    logic [7:0] txq[$], rxq[$];
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    int n_bad = 0;
    // Pulses seen on each error event bit, counted at the edge after they stand.
    int n_ev [7] = '{default: 0};
    rim_top #(.DEPTH(D)) dut (.clock_i(clock_i), .rstn_i(rstn_i), .sfr_req_i(special_function_register),
        .sfr_rdata_o(srd_v), .ext_req_i(xr), .ext_rdata_o(x_v), .cmd_i(cmd),
        .radio_disabled_i(rdis), .rx_active_i(rxa), .lock_fail_i(lf), .rx_abort_i(ab),
        .evt_pending_i(evp), .err_pending_i(erp), .rx_valid_i(rxv), .rx_data_i(rxd),
        .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .tx_active_i(txa),
        .err_event_o(ev), .lock_error_o(le), .irq_o(irq));
    rim_radio_sink u_sink (.clock_i(clock_i), .stall_i(stall), .tx_ready_o(txr),
        .tx_active_o(txa));
    initial forever #4 clock_i = ~clock_i;
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_i) xr = '{a, 1'b1, 1'b0, d};
        @(negedge clock_i) xr.wr = 1'b0;
    endtask
    task automatic xchk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock_i) xr = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clock_i) xr.rd = 1'b0;
        chk("ext_reg", e, x_v);
    endtask
    task automatic sw(input logic [7:0] d);
        @(negedge clock_i) special_function_register = '{DATA_PORT_ADDR, 1'b1, 1'b0, d};
        @(negedge clock_i) special_function_register.wr = 1'b0;
        if (txq.size() < D + 2)
            txq.push_back(d);
    endtask
    task automatic pulse(input rim_cmd_t pc);
        @(negedge clock_i) cmd = pc;
        @(negedge clock_i) cmd = '0;
    endtask
    task automatic pchk(input logic [7:0] e);
        @(negedge clock_i) special_function_register = '{DATA_PORT_ADDR, 1'b0, 1'b1, 8'h00};
        @(negedge clock_i) special_function_register.rd = 1'b0;
        chk("data_port", e, srd_v);
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (rstn_i && txv && txr)
            chk("tx", txq.size() ? txq.pop_front() : 8'h00, txd);
        if (rstn_i)
            for (int b = 0; b < 7; b++)
                n_ev[b] += int'(ev[b]);
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        void'($urandom(85560));
        repeat (20) @(negedge clock_i);
        rstn_i = 1'b1;
        xchk(EVT_MASK_ADDR, 8'h00);
        xchk(ERR_MASK_ADDR, 8'h00);
        xw(EVT_MASK_ADDR, 8'hFF);
        xchk(EVT_MASK_ADDR, 8'h3F);
        xw(ERR_MASK_ADDR, 8'hFF);
        xchk(ERR_MASK_ADDR, 8'h7F);
        xchk(16'h6000, 8'h00);
        for (int i = 0; i < 13; i++) begin
            m = 13'h1 << i;
            xw(EVT_MASK_ADDR, {2'b00, m[5:0]});
            xw(ERR_MASK_ADDR, {1'b0, m[12:6]});
            for (int k = 0; k < 2; k++) begin
                @(negedge clock_i) {erp, evp} = k ? ~m : m;
                repeat (2) @(negedge clock_i);
                chk("irq", {7'h00, k == 0}, {7'h00, irq});
            end
        end
        {erp, evp} = '0;
        for (int i = 0; i < 16; i++) begin
            {rdis, rxa} = 2'($urandom);
            c = 7'h08 << $urandom_range(3);
            if ((c.disable_radio && rdis) || (!rxa && (c.send_ack || c.send_ack_pending
                                                     || c.suppress_ack)))
                n_bad++;
            pulse(c);
        end
        @(negedge clock_i);
        chk("bad_strobe", 8'(n_bad), 8'(n_ev[ERR_BAD_STROBE]));
        @(negedge clock_i) {lf, ab} = 2'b11;
        @(negedge clock_i) {lf, ab} = 2'b00;
        repeat (3) @(negedge clock_i);
        chk("lock", 8'h01, {7'h00, le});
        chk("lock_event", 8'h01, 8'(n_ev[ERR_SYNTH_LOCK]));
        chk("abort_event", 8'h01, 8'(n_ev[ERR_RX_ABORT]));
        pulse(7'h01);
        chk("lock", 8'h00, {7'h00, le});
        for (int i = 0; i < D + 3; i++)
            sw(8'($urandom));
        xchk(TX_COUNT_ADDR, 8'(D + 2));
        chk("tx_over_event", 8'h01, 8'(n_ev[ERR_TX_OVERFLOW]));
        // Non-blocking, so the sink sampling on this same edge sees a settled value.
        stall <= 1'b0;
        for (int w = 0; w < 400 && txq.size() > 0; w++)
            @(negedge clock_i);
        chk("txq", 8'h00, 8'(txq.size()));
        stall <= 1'b1;
        repeat (3) sw(8'($urandom));
        pulse(7'h02);
        txq.delete();
        xchk(TX_COUNT_ADDR, 8'h00);
        for (int i = 0; i < D + 1; i++) begin
            @(negedge clock_i) {rxv, rxd} = {1'b1, 8'($urandom)};
            if (rxq.size() < D)
                rxq.push_back(rxd);
        end
        @(negedge clock_i) rxv = 1'b0;
        xchk(RX_COUNT_ADDR, 8'(D));
        chk("rx_over_event", 8'h01, 8'(n_ev[ERR_RX_OVERFLOW]));
        for (int i = 0; i < 3; i++)
            pchk(rxq.pop_front());
        xchk(RX_COUNT_ADDR, 8'(D - 3));
        pulse(7'h04);
        xchk(RX_COUNT_ADDR, 8'h00);
        pchk(8'h00);
        @(negedge clock_i);
        chk("rx_under_event", 8'h01, 8'(n_ev[ERR_RX_UNDER]));
        conclude();
    end
endmodule
`default_nettype wire
